// ===== hw/ecp_pkg.sv
package ecp_pkg;
  // Register offsets relative to the port base address.
  localparam logic [10:0] OFS_PARALLEL_DATA = 11'h000;
  localparam logic [10:0] OFS_DEVICE_STATUS = 11'h001;
  localparam logic [10:0] OFS_DEVICE_CONTROL = 11'h002;
  localparam logic [10:0] OFS_FIFO_PORT = 11'h400;
  localparam logic [10:0] OFS_IRQ_DMA_SETUP_B = 11'h401;
  localparam logic [10:0] OFS_EXTENDED_CONTROL = 11'h402;
  localparam logic [10:0] OFS_DECODE_MASK = 11'h403;
  // Mode field codes.
  localparam logic [2:0] MODE_SPP = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_COMPAT_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_RESERVED = 3'h5;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;
  // Field positions.
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_ERR_EN_BIT = 4;
  localparam int ECR_DMA_EN_BIT = 3;
  localparam int ECR_SERVICE_BIT = 2;
  localparam int DCR_STROBE_BIT = 0;
  localparam int DCR_AUTOFEED_BIT = 1;
  localparam int DCR_INIT_BIT = 2;
  localparam int DCR_SELECT_IN_BIT = 3;
  localparam int DCR_ACK_INT_EN_BIT = 4;
  localparam int DCR_DIRECTION_BIT = 5;
  localparam int CFGB_IRQ_LEVEL_BIT = 6;
  // Reset and constant values.
  localparam logic [7:0] DATA_LATCH_RESET = 8'h00;
  localparam logic [5:0] DCR_RESET = 6'h00;
  localparam logic [5:0] ECR_CTRL_RESET = 6'h01;
  localparam logic [7:0] CAPABILITY_A_VALUE = 8'h10;
  localparam int FIFO_DEPTH = 16;
  localparam int FREE_SPACE_THRESHOLD = 8;
  localparam int VALID_BYTE_THRESHOLD = 8;
  // Handshake timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_WIDTH_NS = 500;
  localparam int STROBE_CYCLES = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {HS_IDLE, HS_SETUP, HS_STROBE, HS_RELEASE, HS_REV_WAIT} ecp_hs_state_t;

  typedef struct packed {
    logic aen;
    logic io_write_strobe_n;
    logic io_read_strobe_n;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ecp_host_req_t;

  typedef struct packed {
    logic busy;
    logic acknowledge_input;
    logic paper_error_input;
    logic select_input;
    logic fault_input;
  } ecp_periph_status_t;
endpackage : ecp_pkg

// ===== hw/ecp_shared_fifo.sv
`timescale 1ns/10ps
module ecp_shared_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  // Fill side.
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // Drain side.
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  // State.
  output logic full,
  output logic empty,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least two.");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  assign head_data = mem[rd_ptr];
  assign full = count == (AW+1)'(DEPTH);
  assign empty = count == '0;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // A flush or reset empties the buffer so no stale byte leaves afterwards.
  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(do_push);
      rd_ptr <= rd_ptr + AW'(do_pop);
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : ecp_shared_fifo

// ===== hw/ecp_port_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Offset 0 is the data latch in modes 000/001, address FIFO in 011.
// - Offset 400h maps compatible, ECP data, test FIFO or capability A by mode.
// - Mode 100 is enhanced mode only when enabled; mode 101 is reserved.
// - Accesses while address enable is high are ignored; base-relative decode.
// - Data latch clears on reset, loads on write strobe rise, drives pins.
// - Offset 0 reads in plain modes return the live data pin levels.
// - Mode 011 forward writes at offset 0 queue tagged address bytes and send.
// - Status bits 0 to 2 read as zero.
// - Status bits 3 to 6 show fault, select, paper error, acknowledge levels.
// - Status bit 7 shows the inverse of the busy input.
// - Control bits 0 to 5 reset to zero; bits 6 and 7 read zero.
// - Control bits 0,1,3 drive outputs inverted, except strobe in 010/011 and autofeed in 011 come from the handshake; bit 2 drives init directly.
// - Control bit 4 enables an interrupt on acknowledge rising edge.
// - Control bit 5 sets direction, except modes 000 and 010 always output.
// - Mode 010 FIFO bytes go out by strobe/busy handshake, forward only.
// - Mode 011 data FIFO sends when direction 0, collects when direction 1.
// - Mode 110 test FIFO works both ways with no port handshake.
// - Test FIFO never stalls: full writes dropped, empty reads repeat last byte.
// - Test FIFO reads return oldest byte first regardless of direction.
// - In test mode the service flag still fires on both thresholds.
// - Mode 111 capability A at 400h reads 10h; writes ignored.
// - Mode 111 setup B bit 7 reads zero, bit 6 shows interrupt line level.
// - All FIFO windows share one sixteen byte buffer for both directions.
// - The mode field is extended control bits 7 to 5 at 402h.
module ecp_port_regs #(
  parameter int FIFO_DEPTH = ecp_pkg::FIFO_DEPTH,
  parameter int FREE_SPACE_THRESHOLD = ecp_pkg::FREE_SPACE_THRESHOLD,
  parameter int VALID_BYTE_THRESHOLD = ecp_pkg::VALID_BYTE_THRESHOLD
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Host I/O cycle.
  input wire ecp_pkg::ecp_host_req_t host_req,
  input wire logic [9:0] base_address,
  output logic [7:0] host_rdata,
  // Configuration straps.
  input wire logic epp_option_enable,
  input wire logic irq_line_level,
  input wire logic [5:0] irq_dma_select,
  // Peripheral lines.
  input wire ecp_pkg::ecp_periph_status_t periph,
  input wire logic [7:0] parallel_data_pins_in,
  output logic [7:0] parallel_data_pins_out,
  output logic parallel_data_pins_oe,
  output logic strobe_output_n,
  output logic autofeed_output_n,
  output logic initialize_output_n,
  output logic select_in_output_n,
  // Status towards the host.
  output logic ack_irq_pulse,
  output logic epp_mode_active
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam int SCW = $clog2(ecp_pkg::STROBE_CYCLES + 1);

  generate
    if (FREE_SPACE_THRESHOLD < 1 || FREE_SPACE_THRESHOLD > FIFO_DEPTH ||
        VALID_BYTE_THRESHOLD < 1 || VALID_BYTE_THRESHOLD > FIFO_DEPTH) begin : g_bad_thr
      $error("Service thresholds must lie between one and the FIFO depth.");
    end
  endgenerate

  // Stored state.
  logic [7:0] parallel_data_latch;
  logic [5:0] device_control;
  logic [2:0] mode;
  logic err_int_en;
  logic dma_en;
  logic service_interrupt_flag;
  logic [7:0] last_read_byte;
  logic wr_n_q;
  logic rd_n_q;
  logic aen_q;
  logic [10:0] addr_q;
  logic [7:0] wdata_q;
  logic ack_q;
  logic [SCW-1:0] hs_count;
  ecp_pkg::ecp_hs_state_t hs_state;
  ecp_pkg::ecp_hs_state_t next_hs_state;

  // Address decode, only in ordinary I/O cycles.
  wire base_hit = addr_q[9:2] == base_address[9:2] && !aen_q;
  wire [10:0] offset = addr_q & ecp_pkg::OFS_DECODE_MASK;
  wire write_event = wr_n_q == 1'b0 && host_req.io_write_strobe_n && base_hit;
  wire read_event = rd_n_q == 1'b0 && host_req.io_read_strobe_n && base_hit;
  wire reading = !host_req.io_read_strobe_n && base_hit;
  wire sel_data = offset == ecp_pkg::OFS_PARALLEL_DATA;
  wire sel_status = offset == ecp_pkg::OFS_DEVICE_STATUS;
  wire sel_control = offset == ecp_pkg::OFS_DEVICE_CONTROL;
  wire sel_fifo = offset == ecp_pkg::OFS_FIFO_PORT;
  wire sel_cfg_b = offset == ecp_pkg::OFS_IRQ_DMA_SETUP_B;
  wire sel_ecr = offset == ecp_pkg::OFS_EXTENDED_CONTROL;

  // Mode qualifiers.
  wire mode_plain = mode == ecp_pkg::MODE_SPP || mode == ecp_pkg::MODE_BIDIR;
  wire mode_compat = mode == ecp_pkg::MODE_COMPAT_FIFO;
  wire mode_ecp = mode == ecp_pkg::MODE_ECP;
  wire mode_test = mode == ecp_pkg::MODE_TEST;
  wire mode_cfg = mode == ecp_pkg::MODE_CONFIG;
  wire mode_epp = mode == ecp_pkg::MODE_EPP && epp_option_enable;
  wire dir_forced_out = mode == ecp_pkg::MODE_SPP || mode_compat;
  wire direction_in = device_control[ecp_pkg::DCR_DIRECTION_BIT] && !dir_forced_out;

  // Shared FIFO signals.
  logic fifo_full;
  logic fifo_empty;
  logic [CW-1:0] fifo_count;
  logic [8:0] fifo_head;
  logic rev_push;
  logic hs_pop;
  wire addr_push = write_event && sel_data && mode_ecp && !direction_in;
  wire data_push = write_event && sel_fifo &&
                   ((mode_compat || mode_ecp) && !direction_in || mode_test);
  wire host_pop = read_event && sel_fifo &&
                  (mode_ecp && direction_in || mode_test);
  wire fifo_push = addr_push || data_push || rev_push;
  wire [8:0] push_word = rev_push ? {periph.busy, parallel_data_pins_in} :
                         {addr_push, wdata_q};
  wire fifo_pop = host_pop || hs_pop;
  wire fifo_flush = mode_plain;

  // One buffer serves every FIFO window and both directions.
  ecp_shared_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .flush(fifo_flush),
    .push(fifo_push),
    .push_data(push_word),
    .pop(fifo_pop),
    .head_data(fifo_head),
    .full(fifo_full),
    .empty(fifo_empty),
    .count(fifo_count)
  );

  // Service thresholds, also live in test mode.
  wire [CW-1:0] free_space = CW'(FIFO_DEPTH) - fifo_count;
  wire thr_hit = direction_in ? fifo_count >= CW'(VALID_BYTE_THRESHOLD) :
                 free_space >= CW'(FREE_SPACE_THRESHOLD);
  wire service_set = !service_interrupt_flag && !dma_en && thr_hit &&
                     (mode_compat || mode_ecp || mode_test);

  // Register read selection.
  wire [7:0] status_read = {~periph.busy, periph.acknowledge_input, periph.paper_error_input,
                            periph.select_input, periph.fault_input, 3'h0};
  wire [7:0] fifo_byte = fifo_empty ? last_read_byte : fifo_head[7:0];
  wire fifo_readable = mode_ecp && direction_in || mode_test;
  wire [7:0] fifo_read = mode_cfg ? ecp_pkg::CAPABILITY_A_VALUE :
                         fifo_readable ? fifo_byte : 8'h00;
  wire [7:0] cfg_b_read = mode_cfg ? {1'b0, irq_line_level, irq_dma_select} : 8'h00;
  wire [7:0] ecr_read = {mode, err_int_en, dma_en, service_interrupt_flag,
                         fifo_full, fifo_empty};
  wire [7:0] data_read = mode_plain ? parallel_data_pins_in : 8'h00;
  wire [7:0] read_mux = !reading ? 8'h00 :
                        sel_data ? data_read :
                        sel_status ? status_read :
                        sel_control ? {2'h0, device_control} :
                        sel_fifo ? fifo_read :
                        sel_cfg_b ? cfg_b_read :
                        sel_ecr ? ecr_read : 8'h00;

  // Mode switching: extended modes may only return to 000 or 001.
  wire [2:0] new_mode = wdata_q[7:ecp_pkg::ECR_MODE_LSB];
  wire mode_write_ok = mode_plain || new_mode == ecp_pkg::MODE_SPP ||
                       new_mode == ecp_pkg::MODE_BIDIR;
  wire ecr_write = write_event && sel_ecr;

  // Handshake engine.
  wire fwd_ready = (mode_compat || mode_ecp) && !direction_in && !fifo_empty;
  wire rev_ready = mode_ecp && direction_in && !fifo_full;
  wire count_done = hs_count == SCW'(ecp_pkg::STROBE_CYCLES - 1);

  always_comb begin
    next_hs_state = hs_state;
    hs_pop = 1'b0;
    rev_push = 1'b0;
    unique case (hs_state)
      ecp_pkg::HS_IDLE: begin
        if (fwd_ready && !periph.busy) begin
          hs_pop = 1'b1;
          next_hs_state = ecp_pkg::HS_SETUP;
        end else if (rev_ready && !periph.acknowledge_input) begin
          rev_push = 1'b1;
          next_hs_state = ecp_pkg::HS_REV_WAIT;
        end
      end
      ecp_pkg::HS_SETUP: begin
        if (count_done) begin
          next_hs_state = ecp_pkg::HS_STROBE;
        end
      end
      ecp_pkg::HS_STROBE: begin
        if (mode_ecp ? periph.busy : count_done) begin
          next_hs_state = ecp_pkg::HS_RELEASE;
        end
      end
      ecp_pkg::HS_RELEASE: begin
        if (!periph.busy) begin
          next_hs_state = ecp_pkg::HS_IDLE;
        end
      end
      ecp_pkg::HS_REV_WAIT: begin
        if (periph.acknowledge_input) begin
          next_hs_state = ecp_pkg::HS_IDLE;
        end
      end
    endcase
    if (!(mode_compat || mode_ecp)) begin
      next_hs_state = ecp_pkg::HS_IDLE;
    end
  end

  // Pin values from control bits, the data latch, the test FIFO head or the handshake engine.
  logic [7:0] next_pins_out;
  logic next_strobe_n;
  logic next_autofeed_n;
  logic [8:0] hs_byte;
  wire hs_strobing = hs_state == ecp_pkg::HS_STROBE;
  always_comb begin
    next_pins_out = parallel_data_latch;
    next_strobe_n = ~device_control[ecp_pkg::DCR_STROBE_BIT];
    next_autofeed_n = ~device_control[ecp_pkg::DCR_AUTOFEED_BIT];
    if (mode_compat || mode_ecp) begin
      next_pins_out = hs_byte[7:0];
      next_strobe_n = !hs_strobing;
      if (mode_ecp) begin
        next_autofeed_n = direction_in ? hs_state == ecp_pkg::HS_REV_WAIT : hs_byte[8];
      end
    end else if (mode_test && !fifo_empty) begin
      next_pins_out = fifo_head[7:0];
    end
  end

  // Host-side capture of the I/O cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      aen_q <= 1'b1;
      addr_q <= '0;
      wdata_q <= 8'h00;
      ack_q <= 1'b1;
    end else begin
      wr_n_q <= host_req.io_write_strobe_n;
      rd_n_q <= host_req.io_read_strobe_n;
      aen_q <= host_req.aen;
      ack_q <= periph.acknowledge_input;
      if (!host_req.io_write_strobe_n || !host_req.io_read_strobe_n) begin
        addr_q <= host_req.addr;
        wdata_q <= host_req.wdata;
      end
    end
  end

  // Data latch and control register.
  always_ff @(posedge clk) begin
    if (reset) begin
      parallel_data_latch <= ecp_pkg::DATA_LATCH_RESET;
      device_control <= ecp_pkg::DCR_RESET;
    end else begin
      if (write_event && sel_data && mode_plain) begin
        parallel_data_latch <= wdata_q;
      end
      if (write_event && sel_control) begin
        device_control <= wdata_q[5:0];
      end
    end
  end

  // Extended control; a hardware set beats a software clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      {mode, err_int_en, dma_en, service_interrupt_flag} <= ecp_pkg::ECR_CTRL_RESET;
    end else begin
      if (ecr_write && mode_write_ok) begin
        mode <= new_mode;
      end
      if (ecr_write) begin
        err_int_en <= wdata_q[ecp_pkg::ECR_ERR_EN_BIT];
        dma_en <= wdata_q[ecp_pkg::ECR_DMA_EN_BIT];
      end
      if (service_set) begin
        service_interrupt_flag <= 1'b1;
      end else if (ecr_write) begin
        service_interrupt_flag <= wdata_q[ecp_pkg::ECR_SERVICE_BIT];
      end
    end
  end

  // Handshake state and the byte it is presenting.
  always_ff @(posedge clk) begin
    if (reset) begin
      hs_state <= ecp_pkg::HS_IDLE;
      hs_count <= '0;
      hs_byte <= 9'h000;
    end else begin
      hs_state <= next_hs_state;
      hs_count <= next_hs_state != hs_state ? '0 : hs_count + SCW'(!count_done);
      if (hs_pop) begin
        hs_byte <= fifo_head;
      end
    end
  end

  // Read data, repeat byte and registered pin outputs.
  always_ff @(posedge clk) begin
    if (reset) begin
      host_rdata <= 8'h00;
      last_read_byte <= 8'h00;
      parallel_data_pins_out <= 8'h00;
      parallel_data_pins_oe <= 1'b0;
      strobe_output_n <= 1'b1;
      autofeed_output_n <= 1'b1;
      initialize_output_n <= 1'b0;
      select_in_output_n <= 1'b1;
      ack_irq_pulse <= 1'b0;
      epp_mode_active <= 1'b0;
    end else begin
      host_rdata <= read_mux;
      if (host_pop && !fifo_empty) begin
        last_read_byte <= fifo_head[7:0];
      end
      parallel_data_pins_out <= next_pins_out;
      parallel_data_pins_oe <= !direction_in;
      strobe_output_n <= next_strobe_n;
      autofeed_output_n <= next_autofeed_n;
      initialize_output_n <= device_control[ecp_pkg::DCR_INIT_BIT];
      select_in_output_n <= ~device_control[ecp_pkg::DCR_SELECT_IN_BIT];
      ack_irq_pulse <= device_control[ecp_pkg::DCR_ACK_INT_EN_BIT] &&
                       !ack_q && periph.acknowledge_input;
      epp_mode_active <= mode_epp;
    end
  end
endmodule : ecp_port_regs

// ===== tb/ecp_printer_model.sv
`timescale 1ns/10ps
module ecp_printer_model (
  // Clock.
  input wire logic clk,
  // Lines from the port.
  input wire logic strobe_output_n,
  input wire logic [7:0] pins_out,
  input wire logic pins_oe,
  // Bench control: {stall busy, acknowledge, paper error, select, fault}.
  input wire logic [4:0] lvl,
  input wire logic drv_en,
  input wire logic [7:0] drv_val,
  // Lines towards the port.
  output ecp_pkg::ecp_periph_status_t periph,
  output logic [7:0] pins_in
);
  logic busy_hs = 1'b0;
  logic [7:0] last = 8'h00;
  // Busy answers the strobe one cycle late; the bench can hold it high.
  always @(posedge clk) begin
    busy_hs <= ~strobe_output_n;
    if (pins_oe) begin
      last <= pins_out;
    end
  end
  assign periph = {busy_hs | lvl[4], lvl[3:0]};
  // Released lines show drv_val when drv_en is set, else the inverse of the last driven byte.
  assign pins_in = pins_oe ? pins_out : (drv_en ? drv_val : ~last);
endmodule : ecp_printer_model

// ===== tb/ecp_port_regs_assertions.sv
`timescale 1ns/10ps
module ecp_port_regs_assertions #(
  parameter int FIFO_DEPTH = ecp_pkg::FIFO_DEPTH,
  parameter int FREE_SPACE_THRESHOLD = ecp_pkg::FREE_SPACE_THRESHOLD,
  parameter int VALID_BYTE_THRESHOLD = ecp_pkg::VALID_BYTE_THRESHOLD
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Host side.
  input wire ecp_pkg::ecp_host_req_t host_req,
  input wire logic [9:0] base_address,
  input wire logic [7:0] host_rdata,
  input wire logic epp_option_enable,
  input wire logic irq_line_level,
  input wire logic [5:0] irq_dma_select,
  // Peripheral side.
  input wire ecp_pkg::ecp_periph_status_t periph,
  input wire logic [7:0] parallel_data_pins_in,
  input wire logic [7:0] parallel_data_pins_out,
  input wire logic parallel_data_pins_oe,
  input wire logic strobe_output_n,
  input wire logic autofeed_output_n,
  input wire logic initialize_output_n,
  input wire logic select_in_output_n,
  input wire logic ack_irq_pulse,
  input wire logic epp_mode_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire rd_low = !host_req.io_read_strobe_n;
  wire hit = host_req.addr[9:2] == base_address[9:2];
  wire sel = rd_low && hit && !host_req.aen;
  wire rd_aen = rd_low && host_req.aen;
  wire rd_miss = rd_low && !hit;
  wire [2:0] ofs = {host_req.addr[10], host_req.addr[1:0]};
  wire [7:0] stat = {~periph.busy, periph.acknowledge_input, periph.paper_error_input,
    periph.select_input, periph.fault_input, 3'b000};
  a_status_low: assert property (sel ##1 (sel && ofs == 3'h1) |=>
    host_rdata[2:0] == 3'b000)
    else $error("status low bits not zero");
  a_status_bits: assert property (sel ##1 (sel && ofs == 3'h1) |=>
    host_rdata == $past(stat))
    else $error("status bits do not follow the lines");
  a_ctl_high_zero: assert property (sel ##1 (sel && ofs == 3'h2) |=>
    host_rdata[7:6] == 2'b00)
    else $error("control bits 7 and 6 not zero");
  a_reset_outputs: assert property ($past(reset) |->
    parallel_data_pins_out == 8'h00 && strobe_output_n && autofeed_output_n &&
    !initialize_output_n && select_in_output_n)
    else $error("outputs wrong after reset");
  a_irq_single: assert property (ack_irq_pulse |=> !ack_irq_pulse)
    else $error("interrupt pulse longer than one cycle");
  a_irq_after_ack: assert property (ack_irq_pulse |-> $past(periph.acknowledge_input))
    else $error("interrupt pulse without acknowledge high");
  a_aen_read_zero: assert property (rd_aen ##1 rd_aen |=> host_rdata == 8'h00)
    else $error("read answered during address enable");
  a_base_miss_zero: assert property (rd_miss ##1 rd_miss |=> host_rdata == 8'h00)
    else $error("read answered at foreign base");
  a_data_held: assert property (!strobe_output_n && $past(!strobe_output_n) |->
    $stable(parallel_data_pins_out))
    else $error("data changed while strobe low");
  c_status_read: cover property (sel && ofs == 3'h1);
  c_irq: cover property (ack_irq_pulse);
  c_strobe: cover property ($fell(strobe_output_n));
endmodule : ecp_port_regs_assertions
bind ecp_port_regs ecp_port_regs_assertions #(.FIFO_DEPTH(FIFO_DEPTH),
  .FREE_SPACE_THRESHOLD(FREE_SPACE_THRESHOLD), .VALID_BYTE_THRESHOLD(VALID_BYTE_THRESHOLD))
  u_chk (.clk(clk), .reset(reset), .host_req(host_req), .base_address(base_address),
  .host_rdata(host_rdata), .epp_option_enable(epp_option_enable),
  .irq_line_level(irq_line_level), .irq_dma_select(irq_dma_select), .periph(periph),
  .parallel_data_pins_in(parallel_data_pins_in), .parallel_data_pins_out(parallel_data_pins_out),
  .parallel_data_pins_oe(parallel_data_pins_oe), .strobe_output_n(strobe_output_n),
  .autofeed_output_n(autofeed_output_n), .initialize_output_n(initialize_output_n),
  .select_in_output_n(select_in_output_n), .ack_irq_pulse(ack_irq_pulse),
  .epp_mode_active(epp_mode_active));

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module tb_top;
  logic clk, reset, epp_en, irq_lvl, drv_en, prv, seen;
  logic [4:0] lvl;
  logic [7:0] drv_val, r, cd, rdata, pout, pin;
  logic [9:0] hb;
  logic ca, poe, stb_n, afd_n, ini_n, sli_n, irq, epp;
  ecp_pkg::ecp_host_req_t req;
  ecp_pkg::ecp_periph_status_t periph;
  int n_fail, samples_checked, ns, n0, i, k;
  ecp_port_regs uut (.clk(clk), .reset(reset), .host_req(req), .base_address(10'h378),
    .host_rdata(rdata), .epp_option_enable(epp_en), .irq_line_level(irq_lvl),
    .irq_dma_select(6'h15), .periph(periph), .parallel_data_pins_in(pin),
    .parallel_data_pins_out(pout), .parallel_data_pins_oe(poe), .strobe_output_n(stb_n),
    .autofeed_output_n(afd_n), .initialize_output_n(ini_n), .select_in_output_n(sli_n),
    .ack_irq_pulse(irq), .epp_mode_active(epp));
  ecp_printer_model pm (.clk(clk), .strobe_output_n(stb_n), .pins_out(pout), .pins_oe(poe),
    .lvl(lvl), .drv_en(drv_en), .drv_val(drv_val), .periph(periph), .pins_in(pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Captures data and tag at each falling strobe.
  always @(posedge clk) begin
    if (stb_n === 1'b0 && prv === 1'b1) begin
      cd <= pout;
      ca <= afd_n;
      ns <= ns + 1;
    end
    prv <= stb_n;
  end
  function automatic logic [10:0] ad(input logic [10:0] o);
    return {o[10], hb[9:2], o[1:0]};
  endfunction : ad
  task automatic wr(input logic [10:0] o, input logic [7:0] d);
    @(posedge clk);
    #1;
    req.addr = ad(o);
    req.wdata = d;
    req.io_write_strobe_n = 1'b0;
    @(posedge clk);
    #1;
    req.io_write_strobe_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [10:0] o, output logic [7:0] d);
    @(posedge clk);
    #1;
    req.addr = ad(o);
    req.io_read_strobe_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    d = rdata;
    req.io_read_strobe_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : rd
  task automatic wait_stb();
    k = 0;
    while (ns == n0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    #1;
    `CHK(ns, n0 + 1)
  endtask : wait_stb
  task automatic ack_edge();
    lvl[3] = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    lvl[3] = 1'b1;
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      seen = seen | irq;
    end
  endtask : ack_edge
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    req = '{aen: 1'b0, io_write_strobe_n: 1'b1, io_read_strobe_n: 1'b1,
      addr: 11'h000, wdata: 8'h00};
    reset = 1'b1;
    {epp_en, irq_lvl, drv_en, prv, ca} = 5'h00;
    {lvl, drv_val, cd, ns, n_fail, samples_checked} = '0;
    hb = 10'h378;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    `CHK({stb_n, afd_n, ini_n, sli_n}, 4'b1101)
    `CHK(pout, 8'h00)
    rd(11'h002, r);
    `CHK(r, 8'h00)
    rd(11'h402, r);
    `CHK(r, 8'h05)
    wr(11'h000, 8'ha5);
    `CHK(pout, 8'ha5)
    rd(11'h000, r);
    `CHK(r, 8'ha5)
    req.aen = 1'b1;
    wr(11'h000, 8'h11);
    rd(11'h000, r);
    req.aen = 1'b0;
    `CHK(r, 8'h00)
    hb = 10'h278;
    wr(11'h000, 8'h22);
    rd(11'h001, r);
    hb = 10'h378;
    `CHK(r, 8'h00)
    `CHK(pout, 8'ha5)
    wr(11'h002, 8'h20);
    `CHK(poe, 1'b1)
    wr(11'h402, 8'h24);
    `CHK(poe, 1'b0)
    drv_en = 1'b1;
    drv_val = 8'h3c;
    rd(11'h000, r);
    `CHK(r, 8'h3c)
    drv_en = 1'b0;
    wr(11'h002, 8'h00);
    wr(11'h402, 8'h04);
    for (i = 0; i < 32; i++) begin
      lvl = i[4:0];
      rd(11'h001, r);
      `CHK(r, {~lvl[4], lvl[3:0], 3'b000})
    end
    lvl = 5'h00;
    wr(11'h002, 8'hff);
    rd(11'h002, r);
    `CHK(r, 8'h3f)
    `CHK({stb_n, afd_n, ini_n, sli_n}, 4'b0010)
    `CHK(poe, 1'b1)
    ack_edge();
    `CHK(seen, 1'b1)
    wr(11'h002, 8'h00);
    ack_edge();
    `CHK(seen, 1'b0)
    lvl = 5'h00;
    wr(11'h402, 8'he4);
    wr(11'h400, 8'hff);
    rd(11'h400, r);
    `CHK(r, 8'h10)
    irq_lvl = 1'b1;
    rd(11'h401, r);
    `CHK(r, 8'h55)
    irq_lvl = 1'b0;
    rd(11'h401, r);
    `CHK(r, 8'h15)
    wr(11'h402, 8'h04);
    rd(11'h400, r);
    `CHK(r, 8'h00)
    rd(11'h401, r);
    `CHK(r, 8'h00)
    for (i = 0; i < 4; i++) begin
      epp_en = i[1];
      wr(11'h402, i[0] ? 8'ha4 : 8'h84);
      `CHK(epp, i == 2)
      wr(11'h402, 8'h04);
    end
    wr(11'h402, 8'hc0);
    rd(11'h402, r);
    `CHK(r[2:0], 3'b101)
    wr(11'h002, 8'h20);
    wr(11'h402, 8'hc0);
    rd(11'h402, r);
    `CHK(r[2:0], 3'b001)
    for (i = 0; i < 17; i++) begin
      wr(11'h400, 8'(8'h40 + i));
    end
    rd(11'h402, r);
    `CHK(r[2:0], 3'b110)
    for (i = 0; i < 16; i++) begin
      rd(11'h400, r);
      `CHK(r, 8'(8'h40 + i))
    end
    rd(11'h400, r);
    `CHK(r, 8'h4f)
    rd(11'h402, r);
    `CHK(r[1:0], 2'b01)
    wr(11'h400, 8'h01);
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    rd(11'h402, r);
    `CHK(r, 8'h05)
    wr(11'h402, 8'h44);
    n0 = ns;
    wr(11'h400, 8'h99);
    wait_stb();
    `CHK(cd, 8'h99)
    repeat (60) @(posedge clk);
    wr(11'h402, 8'h04);
    wr(11'h402, 8'h64);
    n0 = ns;
    wr(11'h000, 8'h5a);
    wait_stb();
    `CHK({ca, cd}, 9'h15a)
    n0 = ns;
    wr(11'h400, 8'h77);
    wait_stb();
    `CHK({ca, cd}, 9'h077)
    repeat (10) @(posedge clk);
    wr(11'h402, 8'h04);
    lvl = 5'h08;
    {drv_en, drv_val} = 9'h1c3;
    wr(11'h002, 8'h20);
    wr(11'h402, 8'h64);
    lvl = 5'h00;
    repeat (3) @(posedge clk);
    #1 lvl = 5'h08;
    rd(11'h400, r);
    `CHK(r, 8'hc3)
    end_of_test();
  end
endmodule : tb_top
